// File: inc/sdo_defines.svh
// Notes on behaviour
// - Indexed parameters carry 16 or 32 indexes
// - Write access 0 stores all indexes, EEPROM
// - Write access 17/33 stores all indexes, RAM
// - Mux select 1422 indexed 16, via 1420/1421
// - Function table indexed 32, via 1341/1342
// - Master writes cyclic data to RAM only
// - RAM values never touch EEPROM, lost at reset
// - Object index equals parameter number plus 0x2000
// - Access parameter: sub 5, 0x2B, ack 0x60
// - Value at sub 0, 0x23, ack 0x60
// - Master sets read index before reading
// - Four-byte read answered 0x43, little-endian
// - Index selection persists until rewritten or reset
// - 16-bit tolerance at 0x3000/0, microseconds
// - SYNC outside period plus/minus tolerance errors
// - Tolerance 0..17000, clipped to half period
// - Zero tolerance disables SYNC monitoring
// - Configured or measured period monitored alike
// - Tolerance saved by 0x1010 sub 3 and 1
`ifndef SDO_DEFINES_SVH
`define SDO_DEFINES_SVH
`define PARAM_OBJ_BASE 16'h2000
`define PN_WACC16 16'h058C
`define PN_RACC16 16'h058D
`define PN_VAL16 16'h058E
`define PN_WACC32 16'h053D
`define PN_RACC32 16'h053E
`define PN_VAL32 16'h053F
`define OBJ_TOLERANCE 16'h3000
`define OBJ_CYCLE_PERIOD 16'h1006
`define OBJ_STORE 16'h1010
`define SUB_ACCESS 8'h05
`define SUB_VALUE 8'h00
`define SUB_SAVE_ALL 8'h01
`define SUB_SAVE_APP 8'h03
`define SAVE_SIGNATURE 32'h65766173
`define OP_WRITE2 8'h2B
`define OP_WRITE4 8'h23
`define OP_READ 8'h40
`define OP_WRITE_ACK 8'h60
`define OP_READ4_ACK 8'h43
`define OP_READ2_ACK 8'h4B
`define OP_ABORT 8'h80
`define TOL_MAX_US 16'h4268
`define CLK_FREQ_HZ 25000000
`define HZ_PER_MHZ 1000000
`define US_TICK_CYCLES (`CLK_FREQ_HZ / `HZ_PER_MHZ)
`endif

// File: inc/sdo_pkg.sv
package sdo_pkg;
    typedef struct packed {
        logic ok;
        logic all;
        logic nv;
        logic [5:0] idx;
    } access_t;
    typedef enum logic [1:0] {ST_RESTORE, ST_IDLE, ST_RESP} srv_state_t;
    typedef enum logic [1:0] {MS_IDLE, MS_REQ, MS_WAIT} mst_state_t;
endpackage

// File: inc/sdo_link_if.sv
`timescale 1ns/1ps
interface sdo_link_if;
    logic req_valid;
    logic req_ready;
    logic [7:0] req_cmd;
    logic [15:0] req_index;
    logic [7:0] req_sub;
    logic [31:0] req_data;
    logic rsp_valid;
    logic rsp_ready;
    logic [7:0] rsp_cmd;
    logic [15:0] rsp_index;
    logic [7:0] rsp_sub;
    logic [31:0] rsp_data;
    logic sync_pulse;
    modport device (
        input req_valid, req_cmd, req_index, req_sub, req_data, rsp_ready, sync_pulse,
        output req_ready, rsp_valid, rsp_cmd, rsp_index, rsp_sub, rsp_data
    );
    modport master (
        output req_valid, req_cmd, req_index, req_sub, req_data, rsp_ready, sync_pulse,
        input req_ready, rsp_valid, rsp_cmd, rsp_index, rsp_sub, rsp_data
    );
endinterface

// File: src/drive_sdo_server.sv
`timescale 1ns/1ps
`include "sdo_defines.svh"
module drive_sdo_server import sdo_pkg::*; #(
    parameter int N16 = 16,
    parameter int N32 = 32
) (
    input wire logic clock,         // 25 MHz clock
    input wire logic arst_n,        // Power-on reset, volatile state
    input wire logic nv_erase_n,    // Factory erase of non-volatile state
    sdo_link_if.device link,        // SDO and SYNC link
    output logic comm_error,        // SYNC timing error pulse
    output logic eeprom_write,      // Non-volatile write pulse
    output logic [15:0] tolerance,  // Active SYNC tolerance, us
    output logic monitor_armed      // Reference SYNC held
);
    if (N16 != 16 || N32 != 32) begin
        $error("index counts fixed by access encoding");
    end

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    srv_state_t st_q, st_d;
    logic [31:0] live16_q [N16];
    logic [31:0] live16_d [N16];
    logic [31:0] nv16_q [N16];
    logic [31:0] nv16_d [N16];
    logic [31:0] live32_q [N32];
    logic [31:0] live32_d [N32];
    logic [31:0] nv32_q [N32];
    logic [31:0] nv32_d [N32];
    logic [15:0] wacc16_q, wacc16_d, racc16_q, racc16_d;
    logic [15:0] wacc32_q, wacc32_d, racc32_q, racc32_d;
    logic [15:0] tol_q, tol_d, tol_nv_q, tol_nv_d;
    logic [31:0] cfg_period_q, cfg_period_d;
    logic [7:0] rcmd_q, rcmd_d, rsub_q, rsub_d;
    logic [15:0] ridx_q, ridx_d;
    logic [31:0] rdata_q, rdata_d;
    logic ewr_q, ewr_d;
    logic sync_restart;
    access_t acc;

    function automatic access_t decode_access(input logic [15:0] v, input int n);
        access_t a;
        logic [15:0] nn;
        nn = 16'(n);
        a.ok = v <= (nn << 1) + 16'h0001;
        a.all = (v == 16'h0000) || (v == nn + 16'h0001);
        a.nv = v <= nn;
        a.idx = a.nv ? 6'(v - 16'h0001) : 6'(v - nn - 16'h0002);
        return a;
    endfunction

    function automatic logic read_ok(input logic [15:0] v, input int n);
        return (v != 16'h0000) && (v <= 16'(n));
    endfunction

    function automatic logic [15:0] obj_of(input logic [15:0] pn);
        return pn + `PARAM_OBJ_BASE;
    endfunction

    assign link.req_ready = (st_q == ST_IDLE);
    assign link.rsp_valid = (st_q == ST_RESP);
    assign link.rsp_cmd = rcmd_q;
    assign link.rsp_index = ridx_q;
    assign link.rsp_sub = rsub_q;
    assign link.rsp_data = rdata_q;
    assign eeprom_write = ewr_q;
    assign tolerance = tol_q;

    // ------------------------------------------------------------
    // Object access
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        live16_d = live16_q;
        nv16_d = nv16_q;
        live32_d = live32_q;
        nv32_d = nv32_q;
        wacc16_d = wacc16_q;
        racc16_d = racc16_q;
        wacc32_d = wacc32_q;
        racc32_d = racc32_q;
        tol_d = tol_q;
        tol_nv_d = tol_nv_q;
        cfg_period_d = cfg_period_q;
        rcmd_d = rcmd_q;
        ridx_d = ridx_q;
        rsub_d = rsub_q;
        rdata_d = rdata_q;
        ewr_d = 1'b0;
        sync_restart = 1'b0;
        acc = '0;
        unique case (st_q)
            ST_RESTORE: begin
                live16_d = nv16_q;
                live32_d = nv32_q;
                tol_d = tol_nv_q;
                st_d = ST_IDLE;
            end
            ST_IDLE: begin
                if (link.req_valid) begin
                    st_d = ST_RESP;
                    ridx_d = link.req_index;
                    rsub_d = link.req_sub;
                    rdata_d = 32'h00000000;
                    rcmd_d = `OP_ABORT;
                    if (link.req_cmd == `OP_WRITE2 && link.req_sub == `SUB_ACCESS) begin
                        if (link.req_index == obj_of(`PN_WACC16)
                                && decode_access(link.req_data[15:0], N16).ok) begin
                            wacc16_d = link.req_data[15:0];
                            rcmd_d = `OP_WRITE_ACK;
                        end else if (link.req_index == obj_of(`PN_RACC16)
                                && read_ok(link.req_data[15:0], N16)) begin
                            racc16_d = link.req_data[15:0];
                            rcmd_d = `OP_WRITE_ACK;
                        end else if (link.req_index == obj_of(`PN_WACC32)
                                && decode_access(link.req_data[15:0], N32).ok) begin
                            wacc32_d = link.req_data[15:0];
                            rcmd_d = `OP_WRITE_ACK;
                        end else if (link.req_index == obj_of(`PN_RACC32)
                                && read_ok(link.req_data[15:0], N32)) begin
                            racc32_d = link.req_data[15:0];
                            rcmd_d = `OP_WRITE_ACK;
                        end
                    end else if (link.req_cmd == `OP_WRITE4 && link.req_sub == `SUB_VALUE
                            && link.req_index == obj_of(`PN_VAL16)) begin
                        acc = decode_access(wacc16_q, N16);
                        for (int i = 0; i < N16; i++) begin
                            if (acc.all || acc.idx == 6'(i)) begin
                                live16_d[i] = link.req_data;
                                if (acc.nv) begin
                                    nv16_d[i] = link.req_data;
                                end
                            end
                        end
                        ewr_d = acc.nv;
                        rcmd_d = `OP_WRITE_ACK;
                    end else if (link.req_cmd == `OP_WRITE4 && link.req_sub == `SUB_VALUE
                            && link.req_index == obj_of(`PN_VAL32)) begin
                        acc = decode_access(wacc32_q, N32);
                        for (int i = 0; i < N32; i++) begin
                            if (acc.all || acc.idx == 6'(i)) begin
                                live32_d[i] = link.req_data;
                                if (acc.nv) begin
                                    nv32_d[i] = link.req_data;
                                end
                            end
                        end
                        ewr_d = acc.nv;
                        rcmd_d = `OP_WRITE_ACK;
                    end else if (link.req_cmd == `OP_WRITE2 && link.req_sub == `SUB_VALUE
                            && link.req_index == `OBJ_TOLERANCE) begin
                        tol_d = (link.req_data[15:0] > `TOL_MAX_US) ?
                            `TOL_MAX_US : link.req_data[15:0];
                        sync_restart = 1'b1;
                        rcmd_d = `OP_WRITE_ACK;
                    end else if (link.req_cmd == `OP_WRITE4 && link.req_sub == `SUB_VALUE
                            && link.req_index == `OBJ_CYCLE_PERIOD) begin
                        cfg_period_d = link.req_data;
                        sync_restart = 1'b1;
                        rcmd_d = `OP_WRITE_ACK;
                    end else if (link.req_cmd == `OP_WRITE4 && link.req_index == `OBJ_STORE
                            && (link.req_sub == `SUB_SAVE_ALL || link.req_sub == `SUB_SAVE_APP)
                            && link.req_data == `SAVE_SIGNATURE) begin
                        tol_nv_d = tol_q;
                        ewr_d = 1'b1;
                        rcmd_d = `OP_WRITE_ACK;
                    end else if (link.req_cmd == `OP_READ) begin
                        rcmd_d = `OP_READ4_ACK;
                        if (link.req_index == obj_of(`PN_VAL16) && link.req_sub == `SUB_VALUE) begin
                            rdata_d = live16_q[4'(racc16_q - 16'h0001)];
                        end else if (link.req_index == obj_of(`PN_VAL32)
                                && link.req_sub == `SUB_VALUE) begin
                            rdata_d = live32_q[5'(racc32_q - 16'h0001)];
                        end else if (link.req_index == `OBJ_CYCLE_PERIOD
                                && link.req_sub == `SUB_VALUE) begin
                            rdata_d = cfg_period_q;
                        end else if (link.req_sub == `SUB_ACCESS
                                || link.req_index == `OBJ_TOLERANCE) begin
                            rcmd_d = `OP_READ2_ACK;
                            if (link.req_index == obj_of(`PN_WACC16)) begin
                                rdata_d = {16'h0000, wacc16_q};
                            end else if (link.req_index == obj_of(`PN_RACC16)) begin
                                rdata_d = {16'h0000, racc16_q};
                            end else if (link.req_index == obj_of(`PN_WACC32)) begin
                                rdata_d = {16'h0000, wacc32_q};
                            end else if (link.req_index == obj_of(`PN_RACC32)) begin
                                rdata_d = {16'h0000, racc32_q};
                            end else if (link.req_index == `OBJ_TOLERANCE
                                    && link.req_sub == `SUB_VALUE) begin
                                rdata_d = {16'h0000, tol_q};
                            end else begin
                                rcmd_d = `OP_ABORT;
                            end
                        end else begin
                            rcmd_d = `OP_ABORT;
                        end
                    end
                end
            end
            ST_RESP: begin
                if (link.rsp_ready) begin
                    st_d = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= ST_RESTORE;
            live16_q <= '{default: 32'h00000000};
            live32_q <= '{default: 32'h00000000};
            wacc16_q <= 16'h0000;
            racc16_q <= 16'h0001;
            wacc32_q <= 16'h0000;
            racc32_q <= 16'h0001;
            tol_q <= 16'h0000;
            cfg_period_q <= 32'h00000000;
            rcmd_q <= 8'h00;
            ridx_q <= 16'h0000;
            rsub_q <= 8'h00;
            rdata_q <= 32'h00000000;
            ewr_q <= 1'b0;
        end else begin
            st_q <= st_d;
            live16_q <= live16_d;
            live32_q <= live32_d;
            wacc16_q <= wacc16_d;
            racc16_q <= racc16_d;
            wacc32_q <= wacc32_d;
            racc32_q <= racc32_d;
            tol_q <= tol_d;
            cfg_period_q <= cfg_period_d;
            rcmd_q <= rcmd_d;
            ridx_q <= ridx_d;
            rsub_q <= rsub_d;
            rdata_q <= rdata_d;
            ewr_q <= ewr_d;
        end
    end

    always_ff @(posedge clock or negedge nv_erase_n) begin
        if (!nv_erase_n) begin
            nv16_q <= '{default: 32'h00000000};
            nv32_q <= '{default: 32'h00000000};
            tol_nv_q <= 16'h0000;
        end else begin
            nv16_q <= nv16_d;
            nv32_q <= nv32_d;
            tol_nv_q <= tol_nv_d;
        end
    end

    // ------------------------------------------------------------
    // SYNC monitor
    // ------------------------------------------------------------
    logic [4:0] div_q, div_d;
    logic [31:0] us_q, us_d, last_q, last_d, meas_q, meas_d;
    logic ref_q, ref_d, err_q, err_d;
    logic [31:0] period_eff, interval, tol_eff;

    always_comb begin
        div_d = (div_q == 5'(`US_TICK_CYCLES - 1)) ? 5'h00 : div_q + 5'h01;
        us_d = (div_q == 5'(`US_TICK_CYCLES - 1)) ? us_q + 32'h00000001 : us_q;
        last_d = last_q;
        meas_d = meas_q;
        ref_d = ref_q;
        err_d = 1'b0;
        interval = us_q - last_q;
        period_eff = (cfg_period_q != 32'h00000000) ? cfg_period_q : meas_q;
        tol_eff = ({16'h0000, tol_q} > (period_eff >> 1)) ?
            (period_eff >> 1) : {16'h0000, tol_q};
        if (tol_q == 16'h0000 || sync_restart || st_q == ST_RESTORE) begin
            ref_d = 1'b0;
        end else if (link.sync_pulse) begin
            last_d = us_q;
            ref_d = 1'b1;
            if (ref_q) begin
                meas_d = interval;
                err_d = (period_eff != 32'h00000000)
                    && (interval < period_eff - tol_eff
                        || interval > period_eff + tol_eff);
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= 5'h00;
            us_q <= 32'h00000000;
            last_q <= 32'h00000000;
            meas_q <= 32'h00000000;
            ref_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            div_q <= div_d;
            us_q <= us_d;
            last_q <= last_d;
            meas_q <= meas_d;
            ref_q <= ref_d;
            err_q <= err_d;
        end
    end

    assign comm_error = err_q;
    assign monitor_armed = ref_q;
endmodule

// File: src/sdo_master_end.sv
`timescale 1ns/1ps
`include "sdo_defines.svh"
module sdo_master_end import sdo_pkg::*; (
    input wire logic clock,            // 25 MHz clock
    input wire logic arst_n,           // Asynchronous reset
    sdo_link_if.master link,           // SDO and SYNC link
    input wire logic cmd_valid,        // Request offered
    output logic cmd_ready,            // Request taken
    input wire logic [7:0] cmd_byte,   // SDO command byte
    input wire logic [15:0] cmd_index, // Object index
    input wire logic [7:0] cmd_sub,    // Sub-index
    input wire logic [31:0] cmd_data,  // Little-endian payload
    output logic reply_valid,          // Reply pulse
    output logic [7:0] reply_byte,     // Reply command byte
    output logic [31:0] reply_data,    // Reply payload
    input wire logic sync_send,        // Send SYNC pulse
    output logic busy                  // Transfer in flight
);
    // ------------------------------------------------------------
    // Request and reply sequencing
    // ------------------------------------------------------------
    mst_state_t st_q, st_d;
    logic [7:0] op_q, op_d, rb_q, rb_d, sub_q, sub_d;
    logic [15:0] idx_q, idx_d;
    logic [31:0] dat_q, dat_d, rd_q, rd_d;
    logic rv_q, rv_d, sync_q, sync_d;

    always_comb begin
        st_d = st_q;
        op_d = op_q;
        idx_d = idx_q;
        sub_d = sub_q;
        dat_d = dat_q;
        rb_d = rb_q;
        rd_d = rd_q;
        rv_d = 1'b0;
        sync_d = sync_send;
        unique case (st_q)
            MS_IDLE: begin
                if (cmd_valid) begin
                    op_d = cmd_byte;
                    idx_d = cmd_index;
                    sub_d = cmd_sub;
                    dat_d = cmd_data;
                    st_d = MS_REQ;
                end
            end
            MS_REQ: begin
                if (link.req_ready) begin
                    st_d = MS_WAIT;
                end
            end
            MS_WAIT: begin
                if (link.rsp_valid) begin
                    rb_d = link.rsp_cmd;
                    rd_d = link.rsp_data;
                    rv_d = 1'b1;
                    st_d = MS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= MS_IDLE;
            op_q <= 8'h00;
            idx_q <= 16'h0000;
            sub_q <= 8'h00;
            dat_q <= 32'h00000000;
            rb_q <= 8'h00;
            rd_q <= 32'h00000000;
            rv_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            st_q <= st_d;
            op_q <= op_d;
            idx_q <= idx_d;
            sub_q <= sub_d;
            dat_q <= dat_d;
            rb_q <= rb_d;
            rd_q <= rd_d;
            rv_q <= rv_d;
            sync_q <= sync_d;
        end
    end

    assign cmd_ready = (st_q == MS_IDLE);
    assign busy = (st_q != MS_IDLE);
    assign link.req_valid = (st_q == MS_REQ);
    assign link.req_cmd = op_q;
    assign link.req_index = idx_q;
    assign link.req_sub = sub_q;
    assign link.req_data = dat_q;
    assign link.rsp_ready = (st_q == MS_WAIT);
    assign link.sync_pulse = sync_q;
    assign reply_valid = rv_q;
    assign reply_byte = rb_q;
    assign reply_data = rd_q;
endmodule

// File: verification/indexed_param_access_sync_monitor_checker.sv
`timescale 1ns/1ps
module indexed_param_access_sync_monitor_checker (
    input wire logic clock, // Clock
    input wire logic arst_n, // Reset
    input wire logic req_valid, // Offered
    input wire logic req_ready, // Taken
    input wire logic [7:0] req_cmd, // Command
    input wire logic [15:0] req_index, // Object
    input wire logic [7:0] req_sub, // Sub-index
    input wire logic [31:0] req_data, // Payload
    input wire logic rsp_valid, // Answer
    input wire logic rsp_ready, // Accepted
    input wire logic [7:0] rsp_cmd, // Command
    input wire logic [15:0] rsp_index, // Object
    input wire logic [7:0] rsp_sub, // Sub-index
    input wire logic [31:0] rsp_data, // Payload
    input wire logic sync_pulse // SYNC
);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    wire logic take = req_valid && req_ready;
    // ----
    // Link assertions
    // ----
    chk_answer_next: assert property (take |=> rsp_valid && rsp_index == $past(req_index)
        && rsp_sub == $past(req_sub)) else $error("answer missing or misaddressed");
    chk_answer_stands: assert property (rsp_valid && !rsp_ready |=> rsp_valid
        && $stable(rsp_cmd) && $stable(rsp_data)) else $error("answer dropped early");
    chk_ready_blocked: assert property (rsp_valid |-> !req_ready)
        else $error("request taken while answer pending");
    chk_access_ack: assert property (take && req_cmd == 8'h2B && req_sub == 8'h05
        && req_index == 16'h258C && req_data[15:0] <= 16'h0021
        |=> rsp_cmd == 8'h60 && rsp_data == 32'h0) else $error("access write not acknowledged");
    chk_access_refused: assert property (take && req_cmd == 8'h2B && req_sub == 8'h05
        && req_index == 16'h258C && req_data[15:0] > 16'h0021
        |=> rsp_cmd == 8'h80 && rsp_data == 32'h0) else $error("bad access value accepted");
    chk_value_ack: assert property (take && req_cmd == 8'h23 && req_sub == 8'h00
        && req_index == 16'h253F |=> rsp_cmd == 8'h60) else $error("value write not acknowledged");
    chk_read_upload: assert property (take && req_cmd == 8'h40 && req_sub == 8'h00
        && (req_index == 16'h258E || req_index == 16'h253F) |=> rsp_cmd == 8'h43)
        else $error("indexed read answer wrong");
    chk_tol_upload: assert property (take && req_cmd == 8'h40 && req_index == 16'h3000
        && req_sub == 8'h00 |=> rsp_cmd == 8'h4B && rsp_data <= 32'h00004268)
        else $error("tolerance read wrong");
    chk_req_held: assert property (req_valid && !req_ready |=> req_valid
        && $stable(req_index) && $stable(req_data)) else $error("request changed while waiting");
    cover property (take && req_cmd == 8'h23);
    cover property (rsp_valid && rsp_cmd == 8'h80);
    cover property (sync_pulse);
endmodule

// File: verification/test_indexed_param_access_sync_monitor.sv
`timescale 1ns/1ps
module test_indexed_param_access_sync_monitor import sdo_pkg::*;;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic nv_erase_n = 1'b0;
    logic cmd_valid = 1'b0;
    logic sync_send = 1'b0;
    logic [7:0] cmd_byte = 8'h00;
    logic [7:0] cmd_sub = 8'h00;
    logic [15:0] cmd_index = 16'h0000;
    logic [31:0] cmd_data = 32'h0;
    logic cmd_ready, reply_valid, busy, comm_error, eeprom_write, monitor_armed;
    logic [7:0] reply_byte;
    logic [31:0] reply_data;
    logic [15:0] tolerance;
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;
    int n_err = 0;
    int n_wr = 0;
    int w;
    sdo_link_if link();
    drive_sdo_server drive_sdo_server_inst (.clock(clock), .arst_n(arst_n),
        .nv_erase_n(nv_erase_n), .link(link), .comm_error(comm_error),
        .eeprom_write(eeprom_write), .tolerance(tolerance), .monitor_armed(monitor_armed));
    sdo_master_end sdo_master_end_inst (.clock(clock), .arst_n(arst_n), .link(link),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_byte(cmd_byte),
        .cmd_index(cmd_index), .cmd_sub(cmd_sub), .cmd_data(cmd_data),
        .reply_valid(reply_valid), .reply_byte(reply_byte), .reply_data(reply_data),
        .sync_send(sync_send), .busy(busy));
    indexed_param_access_sync_monitor_checker checker_inst (.clock(clock), .arst_n(arst_n),
        .req_valid(link.req_valid), .req_ready(link.req_ready), .req_cmd(link.req_cmd),
        .req_index(link.req_index), .req_sub(link.req_sub), .req_data(link.req_data),
        .rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready), .rsp_cmd(link.rsp_cmd),
        .rsp_index(link.rsp_index), .rsp_sub(link.rsp_sub), .rsp_data(link.rsp_data),
        .sync_pulse(link.sync_pulse));
    initial begin
        forever #20 clock = ~clock;
    end
    // ----
    // Tasks
    // ----
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (comm_error === 1'b1) n_err++;
        if (eeprom_write === 1'b1) n_wr++;
        if (cycles == 60000) begin
            n_fail++;
            final_report();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic [7:0] op, input logic [15:0] ix, input logic [7:0] sb,
            input logic [31:0] d, input logic [7:0] ecb, input logic [31:0] ed);
        int n;
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_byte <= op;
        cmd_index <= ix;
        cmd_sub <= sb;
        cmd_data <= d;
        @(negedge clock);
        while (cmd_ready !== 1'b1) @(negedge clock);
        @(posedge clock);
        cmd_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (reply_valid !== 1'b1 && n < 50);
        check({30'h0, busy, reply_valid}, 32'h1);
        check({24'h0, reply_byte}, {24'h0, ecb});
        check(reply_data, ed);
    endtask
    task automatic sync_at(input int us);
        repeat (us * 25 - 1) @(posedge clock);
        sync_send <= 1'b1;
        @(posedge clock);
        sync_send <= 1'b0;
        repeat (4) @(posedge clock);
    endtask
    task automatic do_reset();
        @(posedge clock);
        arst_n <= 1'b0;
        repeat (8) @(posedge clock);
        arst_n <= 1'b1;
        nv_erase_n <= 1'b1;
        repeat (2) @(posedge clock);
    endtask
    // ----
    // Sequence
    // ----
    initial begin
        do_reset();
        xfer(8'h2B, 16'h253D, 8'h05, 32'h22, 8'h60, 32'h0);
        xfer(8'h23, 16'h253F, 8'h00, 32'h0001E078, 8'h60, 32'h0);
        check(n_wr, 32'h0);
        xfer(8'h2B, 16'h253E, 8'h05, 32'h1, 8'h60, 32'h0);
        repeat (2) xfer(8'h40, 16'h253F, 8'h00, 32'h0, 8'h43, 32'h0001E078);
        xfer(8'h2B, 16'h253E, 8'h05, 32'h2, 8'h60, 32'h0);
        xfer(8'h40, 16'h253F, 8'h00, 32'h0, 8'h43, 32'h0);
        $display("test ram_index done");
        xfer(8'h2B, 16'h258C, 8'h05, 32'h0, 8'h60, 32'h0);
        xfer(8'h23, 16'h258E, 8'h00, 32'h12345678, 8'h60, 32'h0);
        check(32'(n_wr != 0), 32'h1);
        xfer(8'h2B, 16'h258D, 8'h05, 32'h10, 8'h60, 32'h0);
        xfer(8'h40, 16'h258E, 8'h00, 32'h0, 8'h43, 32'h12345678);
        w = n_wr;
        xfer(8'h2B, 16'h258C, 8'h05, 32'h11, 8'h60, 32'h0);
        xfer(8'h23, 16'h258E, 8'h00, 32'hAAAA5555, 8'h60, 32'h0);
        check(n_wr, w);
        xfer(8'h40, 16'h258E, 8'h00, 32'h0, 8'h43, 32'hAAAA5555);
        do_reset();
        xfer(8'h40, 16'h258E, 8'h00, 32'h0, 8'h43, 32'h12345678);
        xfer(8'h2B, 16'h258C, 8'h05, 32'h22, 8'h80, 32'h0);
        xfer(8'h2B, 16'h253D, 8'h05, 32'h42, 8'h80, 32'h0);
        xfer(8'h2B, 16'h258D, 8'h05, 32'h0, 8'h80, 32'h0);
        xfer(8'h40, 16'h2001, 8'h00, 32'h0, 8'h80, 32'h0);
        $display("test storage done");
        xfer(8'h2B, 16'h3000, 8'h00, 32'h5000, 8'h60, 32'h0);
        xfer(8'h40, 16'h3000, 8'h00, 32'h0, 8'h4B, 32'h4268);
        check(32'(tolerance), 32'h4268);
        xfer(8'h23, 16'h1006, 8'h00, 32'd100, 8'h60, 32'h0);
        xfer(8'h2B, 16'h3000, 8'h00, 32'hA, 8'h60, 32'h0);
        sync_at(5);
        sync_at(100);
        sync_at(105);
        sync_at(120);
        check(n_err, 32'h1);
        xfer(8'h2B, 16'h3000, 8'h00, 32'h5000, 8'h60, 32'h0);
        sync_at(5);
        sync_at(160);
        check(n_err, 32'h2);
        xfer(8'h2B, 16'h3000, 8'h00, 32'h0, 8'h60, 32'h0);
        check(32'(monitor_armed), 32'h0);
        sync_at(5);
        sync_at(300);
        check(n_err, 32'h2);
        xfer(8'h23, 16'h1006, 8'h00, 32'h0, 8'h60, 32'h0);
        xfer(8'h2B, 16'h3000, 8'h00, 32'hA, 8'h60, 32'h0);
        sync_at(5);
        repeat (3) sync_at(100);
        sync_at(130);
        check(n_err, 32'h4);
        $display("test sync_monitor done");
        for (int i = 0; i < 2; i++) begin
            xfer(8'h2B, 16'h3000, 8'h00, 32'hA + i, 8'h60, 32'h0);
            xfer(8'h23, 16'h1010, i ? 8'h01 : 8'h03, 32'h65766173, 8'h60, 32'h0);
            xfer(8'h2B, 16'h3000, 8'h00, 32'h20, 8'h60, 32'h0);
            do_reset();
            xfer(8'h40, 16'h3000, 8'h00, 32'h0, 8'h4B, 32'hA + i);
        end
        $display("test save done");
        final_report();
    end
endmodule
